// ---- verilog/afc_cfg.svh ----
// offsets, field positions, reset values and tables of the fan control
`ifndef AFC_CFG_SVH
`define AFC_CFG_SVH

// register offsets
`define AFC_ADDR_SPAN_R1     8'h5f
`define AFC_ADDR_SPAN_LOC    8'h60
`define AFC_ADDR_SPAN_R2     8'h61
`define AFC_ADDR_SLEW_STEP_SEL_ONE_ONE    8'h62
`define AFC_ADDR_SLEW_STEP_SEL_ONE_TWO    8'h63
`define AFC_ADDR_CRIT_R1     8'h6a
`define AFC_ADDR_CRIT_LOC    8'h6b
`define AFC_ADDR_CRIT_R2     8'h6c
`define AFC_ADDR_MARGIN_A    8'h6d
`define AFC_ADDR_MARGIN_B    8'h6e
`define AFC_ADDR_START_R1    8'h70
`define AFC_ADDR_START_LOC   8'h71
`define AFC_ADDR_START_R2    8'h72
`define AFC_ADDR_MIN_ONE     8'h73
`define AFC_ADDR_MIN_TWO     8'h74
`define AFC_ADDR_MIN_THREE   8'h75
`define AFC_ADDR_SRC_MAP     8'h76
`define AFC_ADDR_STATUS      8'h77
`define AFC_ADDR_DUTY_ONE    8'h78
`define AFC_ADDR_DUTY_TWO    8'h79
`define AFC_ADDR_DUTY_THREE  8'h7a

// reset values
`define AFC_RST_SPAN         8'hc0
`define AFC_RST_SLEW_STEP_SEL_ONE         8'h00
`define AFC_RST_CRIT         8'h64
`define AFC_RST_MARGIN_A     8'h44
`define AFC_RST_MARGIN_B     8'h40
`define AFC_RST_START        8'h5a
`define AFC_RST_MIN          8'h40
`define AFC_RST_SRC_MAP      8'h24

// field positions
`define AFC_SPAN_MSB         7
`define AFC_SPAN_LSB         4
`define AFC_MARGIN_HI_MSB    7
`define AFC_MARGIN_HI_LSB    4
`define AFC_MARGIN_LO_MSB    3
`define AFC_MARGIN_LO_LSB    0
`define AFC_KEEP_SPIN_LSB    5
`define AFC_SLEW_EN_ONE      3
`define AFC_SLEW_EN_TWO      7
`define AFC_SLEW_EN_THREE    3
`define AFC_STEP_HI_MSB      6
`define AFC_STEP_HI_LSB      4
`define AFC_STEP_LO_MSB      2
`define AFC_STEP_LO_LSB      0

// duty and temperature figures
`define AFC_FULL_DUTY        8'hff
`define AFC_CRIT_HYST        9'h004
`define AFC_SLOPE_FRAC       4

// slew steps in slots per step code
`define AFC_STEP_0           8'h01
`define AFC_STEP_1           8'h02
`define AFC_STEP_2           8'h03
`define AFC_STEP_3           8'h05
`define AFC_STEP_4           8'h08
`define AFC_STEP_5           8'h0c
`define AFC_STEP_6           8'h18
`define AFC_STEP_7           8'h30

// slots per degree times 16 per span code
`define AFC_SLOPE_0          12'h7f8
`define AFC_SLOPE_1          12'h660
`define AFC_SLOPE_2          12'h4c9
`define AFC_SLOPE_3          12'h3fc
`define AFC_SLOPE_4          12'h330
`define AFC_SLOPE_5          12'h264
`define AFC_SLOPE_6          12'h1fe
`define AFC_SLOPE_7          12'h198
`define AFC_SLOPE_8          12'h132
`define AFC_SLOPE_9          12'h0ff
`define AFC_SLOPE_10         12'h0cc
`define AFC_SLOPE_11         12'h099
`define AFC_SLOPE_12         12'h080
`define AFC_SLOPE_13         12'h066
`define AFC_SLOPE_14         12'h04d
`define AFC_SLOPE_15         12'h033

`endif

// ---- verilog/afc_pkg.sv ----
// types shared by the fan control
package afc_pkg;
  typedef logic [7:0]  afc_byte_t;
  typedef logic [3:0]  afc_nib_t;
  typedef logic [11:0] afc_slope_t;
  typedef enum logic [1:0] {
    AFC_CH_REMOTE_ONE,
    AFC_CH_LOCAL,
    AFC_CH_REMOTE_TWO
  } afc_chan_e;
endpackage : afc_pkg

// ---- verilog/afc_fan_ctrl.sv ----
// automatic fan duty control with critical override and slew limiter
// What this block does
// [R1] span code in upper nibble, sixteen spans
// [R2] span registers 0x5f, 0x60, 0x61 per channel
// [R3] over critical limit forces all fans full
// [R4] full duty holds down to limit minus four
// [R5] critical override unmaskable, beats all settings
// [R6] critical limits 0x6a-0x6c, reset 0x64
// [R7] fan keeps running down to start minus margin
// [R8] off margin 1 to 15, default 4
// [R9] margins in 0x6d and 0x6e nibbles
// [R10] 0x62 bits 7:5 choose off or minimum
// [R11] keep-spin output ignores off margin
// [R12] slew enables at 0x62.3, 0x63.7, 0x63.3
// [R13] slew chosen independently per output
// [R14] without slew, new duty applies at once
// [R15] duty counts slots out of 255
// [R16] step choices 1,2,3,5,8,12,24,48 slots
// [R17] step toward target up or down
// [R18] stepped value kept as previous duty
// [R19] software disables spin-up when slewing
// [R20] 0x62 bits 2:0 select output one step
// [R21] 0x63 bits 6:4 and 2:0 select steps
// [R22] limiter lands on target, stays in range
//
// Our own choice: strobed register access.
`timescale 1ns/1ps
`include "afc_cfg.svh"

module afc_fan_ctrl
(
  // clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rst_b,
  // register port
  input  wire logic [7:0]        reg_addr,
  input  wire afc_pkg::afc_byte_t reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output afc_pkg::afc_byte_t     reg_rdata,
  // measured temperatures
  input  wire afc_pkg::afc_byte_t temp_remote_one,
  input  wire afc_pkg::afc_byte_t temp_local,
  input  wire afc_pkg::afc_byte_t temp_remote_two,
  input  wire logic              temp_update,
  // fan duty outputs
  output afc_pkg::afc_byte_t     fan_drive_one,
  output afc_pkg::afc_byte_t     fan_drive_two,
  output afc_pkg::afc_byte_t     fan_drive_three,
  output logic                   critical_override
);
  import afc_pkg::*;

  afc_byte_t remote_one_span_config;
  afc_byte_t local_span_config;
  afc_byte_t remote_two_span_config;
  afc_byte_t acoustic_control_one;
  afc_byte_t acoustic_control_two;
  afc_byte_t remote_one_critical_limit;
  afc_byte_t local_critical_limit;
  afc_byte_t remote_two_critical_limit;
  afc_byte_t remote_one_local_off_margin;
  afc_byte_t remote_two_off_margin;
  afc_byte_t remote_one_start_temp;
  afc_byte_t local_start_temp;
  afc_byte_t remote_two_start_temp;
  afc_byte_t out_one_min_duty;
  afc_byte_t out_two_min_duty;
  afc_byte_t out_three_min_duty;
  afc_byte_t fan_source_map;

  afc_byte_t   temp_c        [3];
  afc_byte_t   crit_limit_c  [3];
  afc_byte_t   start_temp_c  [3];
  afc_nib_t    temp_span_code[3];
  afc_nib_t    fan_off_margin[3];
  logic [2:0]  crit_c;
  logic [2:0]  fan_run_c;
  logic [15:0] rise_c        [3];

  afc_byte_t   min_duty_o    [3];
  afc_byte_t   duty_o        [3];
  logic [2:0]  keep_spin_o;
  logic [2:0]  slew_en_o;
  logic [2:0]  step_sel_o    [3];
  logic [1:0]  src_o         [3];

  // register writes
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      remote_one_span_config      <= `AFC_RST_SPAN; // R1
      local_span_config           <= `AFC_RST_SPAN;
      remote_two_span_config      <= `AFC_RST_SPAN;
      acoustic_control_one        <= `AFC_RST_SLEW_STEP_SEL_ONE;
      acoustic_control_two        <= `AFC_RST_SLEW_STEP_SEL_ONE;
      remote_one_critical_limit   <= `AFC_RST_CRIT; // R6
      local_critical_limit        <= `AFC_RST_CRIT;
      remote_two_critical_limit   <= `AFC_RST_CRIT;
      remote_one_local_off_margin <= `AFC_RST_MARGIN_A; // R8
      remote_two_off_margin       <= `AFC_RST_MARGIN_B;
      remote_one_start_temp       <= `AFC_RST_START;
      local_start_temp            <= `AFC_RST_START;
      remote_two_start_temp       <= `AFC_RST_START;
      out_one_min_duty            <= `AFC_RST_MIN;
      out_two_min_duty            <= `AFC_RST_MIN;
      out_three_min_duty          <= `AFC_RST_MIN;
      fan_source_map              <= `AFC_RST_SRC_MAP;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        `AFC_ADDR_SPAN_R1:   remote_one_span_config      <= reg_wdata;
        `AFC_ADDR_SPAN_LOC:  local_span_config           <= reg_wdata;
        `AFC_ADDR_SPAN_R2:   remote_two_span_config      <= reg_wdata;
        `AFC_ADDR_SLEW_STEP_SEL_ONE_ONE:  acoustic_control_one        <= reg_wdata;
        `AFC_ADDR_SLEW_STEP_SEL_ONE_TWO:  acoustic_control_two        <= reg_wdata;
        `AFC_ADDR_CRIT_R1:   remote_one_critical_limit   <= reg_wdata;
        `AFC_ADDR_CRIT_LOC:  local_critical_limit        <= reg_wdata;
        `AFC_ADDR_CRIT_R2:   remote_two_critical_limit   <= reg_wdata;
        `AFC_ADDR_MARGIN_A:  remote_one_local_off_margin <= reg_wdata;
        `AFC_ADDR_MARGIN_B:  remote_two_off_margin       <= reg_wdata;
        `AFC_ADDR_START_R1:  remote_one_start_temp       <= reg_wdata;
        `AFC_ADDR_START_LOC: local_start_temp            <= reg_wdata;
        `AFC_ADDR_START_R2:  remote_two_start_temp       <= reg_wdata;
        `AFC_ADDR_MIN_ONE:   out_one_min_duty            <= reg_wdata;
        `AFC_ADDR_MIN_TWO:   out_two_min_duty            <= reg_wdata;
        `AFC_ADDR_MIN_THREE: out_three_min_duty          <= reg_wdata;
        `AFC_ADDR_SRC_MAP:   fan_source_map              <= reg_wdata;
        default:             ;
      endcase
    end
  end

  // register reads, data in the following cycle
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
      reg_rdata <= 8'h00;
    else if (reg_rd)
    begin
      case (reg_addr)
        `AFC_ADDR_SPAN_R1:   reg_rdata <= remote_one_span_config;
        `AFC_ADDR_SPAN_LOC:  reg_rdata <= local_span_config;
        `AFC_ADDR_SPAN_R2:   reg_rdata <= remote_two_span_config;
        `AFC_ADDR_SLEW_STEP_SEL_ONE_ONE:  reg_rdata <= acoustic_control_one;
        `AFC_ADDR_SLEW_STEP_SEL_ONE_TWO:  reg_rdata <= acoustic_control_two;
        `AFC_ADDR_CRIT_R1:   reg_rdata <= remote_one_critical_limit;
        `AFC_ADDR_CRIT_LOC:  reg_rdata <= local_critical_limit;
        `AFC_ADDR_CRIT_R2:   reg_rdata <= remote_two_critical_limit;
        `AFC_ADDR_MARGIN_A:  reg_rdata <= remote_one_local_off_margin;
        `AFC_ADDR_MARGIN_B:  reg_rdata <= remote_two_off_margin;
        `AFC_ADDR_START_R1:  reg_rdata <= remote_one_start_temp;
        `AFC_ADDR_START_LOC: reg_rdata <= local_start_temp;
        `AFC_ADDR_START_R2:  reg_rdata <= remote_two_start_temp;
        `AFC_ADDR_MIN_ONE:   reg_rdata <= out_one_min_duty;
        `AFC_ADDR_MIN_TWO:   reg_rdata <= out_two_min_duty;
        `AFC_ADDR_MIN_THREE: reg_rdata <= out_three_min_duty;
        `AFC_ADDR_SRC_MAP:   reg_rdata <= fan_source_map;
        `AFC_ADDR_STATUS:    reg_rdata <= {2'b00, fan_run_c, crit_c};
        `AFC_ADDR_DUTY_ONE:  reg_rdata <= duty_o[0];
        `AFC_ADDR_DUTY_TWO:  reg_rdata <= duty_o[1];
        `AFC_ADDR_DUTY_THREE: reg_rdata <= duty_o[2];
        default:             reg_rdata <= 8'h00;
      endcase
    end
    else
      reg_rdata <= 8'h00;
  end

  // channel views of the registers
  assign temp_c[AFC_CH_REMOTE_ONE] = temp_remote_one;
  assign temp_c[AFC_CH_LOCAL]      = temp_local;
  assign temp_c[AFC_CH_REMOTE_TWO] = temp_remote_two;

  assign crit_limit_c[0] = remote_one_critical_limit;
  assign crit_limit_c[1] = local_critical_limit;
  assign crit_limit_c[2] = remote_two_critical_limit;

  assign start_temp_c[0] = remote_one_start_temp;
  assign start_temp_c[1] = local_start_temp;
  assign start_temp_c[2] = remote_two_start_temp;

  assign temp_span_code[0] =
    remote_one_span_config[`AFC_SPAN_MSB:`AFC_SPAN_LSB]; // R2
  assign temp_span_code[1] =
    local_span_config[`AFC_SPAN_MSB:`AFC_SPAN_LSB]; // R2
  assign temp_span_code[2] =
    remote_two_span_config[`AFC_SPAN_MSB:`AFC_SPAN_LSB]; // R2

  assign fan_off_margin[0] = remote_one_local_off_margin
    [`AFC_MARGIN_HI_MSB:`AFC_MARGIN_HI_LSB]; // R9
  assign fan_off_margin[1] = remote_one_local_off_margin
    [`AFC_MARGIN_LO_MSB:`AFC_MARGIN_LO_LSB]; // R9
  assign fan_off_margin[2] = remote_two_off_margin
    [`AFC_MARGIN_HI_MSB:`AFC_MARGIN_HI_LSB]; // R9

  // output views of the registers
  assign min_duty_o[0] = out_one_min_duty;
  assign min_duty_o[1] = out_two_min_duty;
  assign min_duty_o[2] = out_three_min_duty;

  assign keep_spin_o = acoustic_control_one
    [`AFC_KEEP_SPIN_LSB+2:`AFC_KEEP_SPIN_LSB]; // R10

  assign slew_en_o[0] = acoustic_control_one[`AFC_SLEW_EN_ONE]; // R12
  assign slew_en_o[1] = acoustic_control_two[`AFC_SLEW_EN_TWO]; // R12
  assign slew_en_o[2] = acoustic_control_two[`AFC_SLEW_EN_THREE]; // R12

  assign step_sel_o[0] =
    acoustic_control_one[`AFC_STEP_LO_MSB:`AFC_STEP_LO_LSB]; // R20
  assign step_sel_o[1] =
    acoustic_control_two[`AFC_STEP_HI_MSB:`AFC_STEP_HI_LSB]; // R21
  assign step_sel_o[2] =
    acoustic_control_two[`AFC_STEP_LO_MSB:`AFC_STEP_LO_LSB]; // R21

  assign src_o[0] = fan_source_map[1:0];
  assign src_o[1] = fan_source_map[3:2];
  assign src_o[2] = fan_source_map[5:4];

  // per-channel critical state, fan state and duty rise
  genvar gc;
  generate
    for (gc = 0; gc < 3; gc++)
    begin : g_chan
      logic [8:0]  temp_w;
      logic [8:0]  lim_w;
      logic [8:0]  start_w;
      afc_byte_t   above;
      afc_slope_t  slope;
      logic [19:0] prod;

      assign temp_w  = {1'b0, temp_c[gc]};
      assign lim_w   = {1'b0, crit_limit_c[gc]};
      assign start_w = {1'b0, start_temp_c[gc]};

      // critical flag, set checked first
      always_ff @(posedge clk_sys)
      begin
        if (!rst_b)
          crit_c[gc] <= 1'b0;
        else if (temp_w > lim_w)
          crit_c[gc] <= 1'b1; // R3
        else if (temp_w + `AFC_CRIT_HYST < lim_w)
          crit_c[gc] <= 1'b0; // R4
      end

      // on at start temperature, off below start minus margin
      always_ff @(posedge clk_sys)
      begin
        if (!rst_b)
          fan_run_c[gc] <= 1'b0;
        else if (temp_update)
        begin
          if (temp_w >= start_w)
            fan_run_c[gc] <= 1'b1;
          else if (temp_w + {5'h00, fan_off_margin[gc]} < start_w)
            fan_run_c[gc] <= 1'b0; // R7
        end
      end

      // slots above minimum, from span slope
      assign above = (temp_w > start_w) ?
                     8'(temp_c[gc] - start_temp_c[gc]) : 8'h00;
      // slots per degree times 16 for the span code
      always_comb
      begin
        case (temp_span_code[gc])
          4'h0:    slope = `AFC_SLOPE_0; // R1
          4'h1:    slope = `AFC_SLOPE_1;
          4'h2:    slope = `AFC_SLOPE_2;
          4'h3:    slope = `AFC_SLOPE_3;
          4'h4:    slope = `AFC_SLOPE_4;
          4'h5:    slope = `AFC_SLOPE_5;
          4'h6:    slope = `AFC_SLOPE_6;
          4'h7:    slope = `AFC_SLOPE_7;
          4'h8:    slope = `AFC_SLOPE_8;
          4'h9:    slope = `AFC_SLOPE_9;
          4'ha:    slope = `AFC_SLOPE_10;
          4'hb:    slope = `AFC_SLOPE_11;
          4'hc:    slope = `AFC_SLOPE_12;
          4'hd:    slope = `AFC_SLOPE_13;
          4'he:    slope = `AFC_SLOPE_14;
          4'hf:    slope = `AFC_SLOPE_15;
          default: slope = `AFC_SLOPE_12;
        endcase
      end

      assign prod  = 20'(above * slope);
      assign rise_c[gc] = prod[19:`AFC_SLOPE_FRAC];
    end
  endgenerate

  assign critical_override = |crit_c;

  // per-output target and slew limiter
  genvar go;
  generate
    for (go = 0; go < 3; go++)
    begin : g_out
      logic [1:0]  ch;
      logic [16:0] sum;
      afc_byte_t   target;
      afc_byte_t   step;
      afc_byte_t   prev;
      afc_byte_t   gap;
      afc_byte_t   next_duty;

      assign ch   = (src_o[go] == 2'b11) ? 2'b00 : src_o[go];
      assign prev = duty_o[go];
      assign sum  = {1'b0, rise_c[ch]} + {9'h000, min_duty_o[go]};

      always_comb
      begin
        if (!fan_run_c[ch])
          target = keep_spin_o[go] ? min_duty_o[go] : 8'h00; // R10
        else if (temp_c[ch] < start_temp_c[ch])
          target = min_duty_o[go]; // R11
        else if (sum > 17'(`AFC_FULL_DUTY))
          target = `AFC_FULL_DUTY; // R15
        else
          target = sum[7:0];
      end

      // slew step in slots for the step code
      always_comb
      begin
        case (step_sel_o[go])
          3'h0:    step = `AFC_STEP_0; // R16
          3'h1:    step = `AFC_STEP_1;
          3'h2:    step = `AFC_STEP_2;
          3'h3:    step = `AFC_STEP_3;
          3'h4:    step = `AFC_STEP_4;
          3'h5:    step = `AFC_STEP_5;
          3'h6:    step = `AFC_STEP_6;
          3'h7:    step = `AFC_STEP_7;
          default: step = `AFC_STEP_0;
        endcase
      end

      assign gap  = (target > prev) ? 8'(target - prev)
                                    : 8'(prev - target);

      always_comb
      begin
        if (!slew_en_o[go])
          next_duty = target; // R14 R13
        else if (gap <= step)
          next_duty = target; // R22
        else if (target > prev)
          next_duty = 8'(prev + step); // R17
        else
          next_duty = 8'(prev - step); // R17
      end

      // duty held as previous value for next comparison
      always_ff @(posedge clk_sys)
      begin
        if (!rst_b)
          duty_o[go] <= 8'h00;
        else if (critical_override)
          duty_o[go] <= `AFC_FULL_DUTY; // R3 R5
        else if (temp_update)
          duty_o[go] <= next_duty; // R18
      end
    end
  endgenerate

  assign fan_drive_one   = duty_o[0];
  assign fan_drive_two   = duty_o[1];
  assign fan_drive_three = duty_o[2];

endmodule : afc_fan_ctrl

// ---- tb/afc_fan_ctrl_checker.sv ----
// port assertions of the fan duty control
`timescale 1ns/1ps
module afc_fan_ctrl_checker
  import afc_pkg::*;
(
  // clock and reset
  input wire logic               clk_sys,
  input wire logic               rst_b,
  // register port
  input wire logic [7:0]         reg_addr,
  input wire logic               reg_rd,
  input wire afc_pkg::afc_byte_t reg_rdata,
  // fan side
  input wire logic               temp_update,
  input wire afc_pkg::afc_byte_t fan_drive_one,
  input wire afc_pkg::afc_byte_t fan_drive_two,
  input wire afc_pkg::afc_byte_t fan_drive_three,
  input wire logic               critical_override
);
  logic full;
  assign full = fan_drive_one == 8'hff && fan_drive_two == 8'hff
    && fan_drive_three == 8'hff;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);
  crit_full_a: assert property (
    critical_override |=> full)
    else $error("duty not full under override");
  crit_exit_a: assert property (
    $fell(critical_override) |-> full)
    else $error("duty left full before next update");
  duty_hold_a: assert property (
    !temp_update && !critical_override |=> $stable(fan_drive_one)
      && $stable(fan_drive_two) && $stable(fan_drive_three))
    else $error("duty moved without update");
  rdata_idle_a: assert property (
    !reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside read cycle");
  unmapped_zero_a: assert property (
    reg_rd && (reg_addr < 8'h5f || reg_addr > 8'h7a
      || reg_addr inside {[8'h64:8'h69], 8'h6f}) |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  duty_read_a: assert property (
    reg_rd && reg_addr == 8'h78 |=> reg_rdata == $past(fan_drive_one))
    else $error("duty one readback wrong");
  duty_read3_a: assert property (
    reg_rd && reg_addr == 8'h7a |=> reg_rdata == $past(fan_drive_three))
    else $error("duty three readback wrong");
  status_crit_a: assert property (
    reg_rd && reg_addr == 8'h77 |=> (|reg_rdata[2:0])
      == $past(critical_override))
    else $error("status critical bits wrong");
endmodule : afc_fan_ctrl_checker

bind afc_fan_ctrl afc_fan_ctrl_checker chk_i (
  .clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .temp_update(temp_update),
  .fan_drive_one(fan_drive_one), .fan_drive_two(fan_drive_two),
  .fan_drive_three(fan_drive_three),
  .critical_override(critical_override));

// ---- tb/afc_fan_model.sv ----
// fan load that follows its drive duty with inertia
`timescale 1ns/1ps
module afc_fan_model
  import afc_pkg::*;
(
  // clock and reset
  input wire logic               clk_sys,
  input wire logic               rst_b,
  // drive and resulting spin
  input wire afc_pkg::afc_byte_t duty,
  output afc_pkg::afc_byte_t     speed
);
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
      speed <= 8'h00;
    else if (speed != duty)
      speed <= speed < duty ? speed + 8'h01 : speed - 8'h01;
  end
endmodule : afc_fan_model

// ---- tb/auto_fan_duty_slew_control_test.sv ----
// self-checking bench of the fan duty control
`timescale 1ns/1ps
module auto_fan_duty_slew_control_test;
  import afc_pkg::*;
  logic       clk_sys;
  logic       rst_b;
  logic [7:0] reg_addr;
  afc_byte_t  reg_wdata, reg_rdata, v, w, spin_one, spin_two;
  int         sc [3] = '{12, 12, 12};
  real        sp [16] = '{2.0, 2.5, 3.33, 4.0, 5.0, 6.67, 8.0, 10.0,
                          13.33, 16.0, 20.0, 26.67, 32.0, 40.0, 53.33,
                          80.0};
  logic       reg_wr, reg_rd, temp_update, critical_override;
  afc_byte_t  temp_remote_one, temp_local, temp_remote_two;
  afc_byte_t  fan_drive_one, fan_drive_two, fan_drive_three;
  int         err_total, checks_done, seed;
  int         duty [3], run [3], kb [3], en [3], stp [3], mg [3];
  int         st [8] = '{1, 2, 3, 5, 8, 12, 24, 48};
  int         seq [9] = '{95, 95, 120, 88, 88, 80, 80, 74, 74};
  afc_byte_t  adr [11] = '{8'h5f, 8'h60, 8'h61, 8'h62, 8'h63, 8'h6a,
                           8'h6b, 8'h6c, 8'h6d, 8'h6e, 8'h65};
  afc_byte_t  rv [11] = '{8'hc0, 8'hc0, 8'hc0, 8'h00, 8'h00, 8'h64,
                          8'h64, 8'h64, 8'h44, 8'h40, 8'h00};

  afc_fan_ctrl uut (
    .clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .temp_remote_one(temp_remote_one),
    .temp_local(temp_local), .temp_remote_two(temp_remote_two),
    .temp_update(temp_update), .fan_drive_one(fan_drive_one),
    .fan_drive_two(fan_drive_two), .fan_drive_three(fan_drive_three),
    .critical_override(critical_override));
  afc_fan_model fan_one (.clk_sys(clk_sys), .rst_b(rst_b),
    .duty(fan_drive_one), .speed(spin_one));
  afc_fan_model fan_two (.clk_sys(clk_sys), .rst_b(rst_b),
    .duty(fan_drive_two), .speed(spin_two));

  task automatic chk(input afc_byte_t seen, input afc_byte_t exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
    end
  endtask : chk

  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : stop_test

  task automatic wr(input afc_byte_t a, input afc_byte_t d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input afc_byte_t a, output afc_byte_t d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    d = reg_rdata;
  endtask : rd

  task automatic put(input int t, input logic u);
    @(posedge clk_sys);
    temp_remote_one <= 8'(t);
    temp_local <= 8'(t);
    temp_remote_two <= 8'(t);
    temp_update <= u;
    @(posedge clk_sys);
    temp_update <= 1'b0;
  endtask : put

  task automatic upd(input int t);
    int tg;
    int d;
    put(t, 1'b1);
    @(negedge clk_sys);
    for (int i = 0; i < 3; i++)
    begin
      tg = run[i] == 0 ? kb[i] * 64 : t < 90 ? 64
         : 64 + (((t - 90) * $rtoi(4080.0 / sp[sc[i]] + 0.5)) >> 4);
      tg = tg > 255 ? 255 : tg;
      d = tg - duty[i];
      d = d > stp[i] ? stp[i] : d < -stp[i] ? -stp[i] : d;
      duty[i] = en[i] != 0 ? duty[i] + d : tg;
      run[i] = t >= 90 ? 1 : t + mg[i] < 90 ? 0 : run[i];
    end
    chk(fan_drive_one, 8'(duty[0]));
    chk(fan_drive_two, 8'(duty[1]));
    chk(fan_drive_three, 8'(duty[2]));
  endtask : upd

  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  initial
  begin
    repeat (100000) @(posedge clk_sys);
    err_total++;
    stop_test;
  end

  initial
  begin
    seed = 32'hef29;
    rst_b = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    temp_update = 1'b0;
    temp_remote_one = 8'h19;
    temp_local = 8'h19;
    temp_remote_two = 8'h19;
    repeat (4) @(posedge clk_sys);
    rst_b <= 1'b1;
    wr(8'h65, 8'h77);
    for (int i = 0; i < 11; i++)
    begin
      rd(adr[i], v);
      chk(v, rv[i]);
    end
    for (int i = 0; i < 10; i++)
    begin
      v = 8'($random(seed)) | (i > 4 && i < 8 ? 8'h80 : 8'h00);
      wr(adr[i], v);
      rd(adr[i], w);
      v = v & (i < 3 || i == 9 ? 8'hf0 : 8'hff);
      chk(w & (i < 3 || i == 9 ? 8'hf0 : 8'hff), v);
      wr(adr[i], rv[i]);
    end
    // spin-up never requested while slewing
    wr(8'h6d, 8'hf1);
    wr(8'h62, 8'h20);
    wr(8'h63, 8'hbf);
    for (int i = 5; i < 8; i++)
      wr(adr[i], 8'hc8);
    mg = '{15, 1, 4};
    kb = '{1, 0, 0};
    en = '{0, 1, 1};
    stp = '{1, 5, 48};
    foreach (seq[i])
      upd(seq[i]);
    rd(8'h78, v);
    chk(v, 8'(duty[0]));
    for (int c = 0; c < 8; c++)
    begin
      wr(8'h62, 8'h28 | 8'(c));
      wr(8'h63, 8'h88 | 8'(c << 4) | 8'(7 - c));
      en = '{1, 1, 1};
      stp = '{st[c], st[c], st[7 - c]};
      repeat (2) upd(90 + {$random(seed)} % 41);
    end
    wr(8'h62, 8'h20);
    en[0] = 0;
    for (int k = 0; k < 16; k++)
    begin
      wr(8'h5f, 8'(k << 4));
      sc[0] = k;
      upd(91);
    end
    wr(8'h5f, 8'hc0);
    sc[0] = 12;
    for (int i = 5; i < 8; i++)
      wr(adr[i], 8'h64);
    put(101, 1'b0);
    repeat (2) @(negedge clk_sys);
    chk({7'h00, critical_override}, 8'h01);
    chk(fan_drive_two, 8'hff);
    put(102, 1'b1);
    @(negedge clk_sys);
    chk(fan_drive_three, 8'hff);
    rd(8'h77, v);
    chk({5'h00, v[2:0]}, 8'h07);
    rd(8'h7a, v);
    chk(v, 8'hff);
    put(96, 1'b0);
    repeat (2) @(negedge clk_sys);
    chk({7'h00, critical_override}, 8'h01);
    put(95, 1'b0);
    repeat (2) @(negedge clk_sys);
    chk({7'h00, critical_override}, 8'h00);
    chk(fan_drive_one, 8'hff);
    duty = '{255, 255, 255};
    upd(95);
    upd(95);
    repeat (256) @(negedge clk_sys);
    chk(spin_one, fan_drive_one);
    chk(spin_two, fan_drive_two);
    stop_test;
  end
endmodule : auto_fan_duty_slew_control_test
